/* common/lpm_defs.svh */
// lpm_defs.svh: offsets, fields, reset values and timing counts
// assumes: included by bare name after lpm_pkg
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define LPM_A_CTRL 6'h00
`define LPM_A_FREQ 6'h04
`define LPM_A_STAT 6'h08
`define LPM_A_IRQS 6'h0c
`define LPM_A_IRQC 6'h10
`define LPM_A_IRQE 6'h14

// ----------------------------------------
// control and interrupt fields
// ----------------------------------------
`define LPM_F_MODE 2:0
`define LPM_F_GO 3
`define LPM_F_RANGE 5:4
`define LPM_F_LSI 6
`define LPM_F_LSE 7
`define LPM_F_INDEPENDENT_WATCHDOG 8
`define LPM_IRQ_W 3
`define LPM_I_WAKE 0
`define LPM_I_REFUSE 1
`define LPM_I_STEP 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define LPM_RANGE_RST 2'h2
`define LPM_FREQ_RST 16'h0831

// ----------------------------------------
// frequency limits in kHz
// ----------------------------------------
`define LPM_R1_MAX 16'h7d00
`define LPM_R2_MAX 16'h3e80
`define LPM_R3_MAX 16'h1068
`define LPM_WS_R1 16'h3e80
`define LPM_WS_R2 16'h1f40
`define LPM_LPRUN_MAX 16'h0083

// ----------------------------------------
// timing
// ----------------------------------------
`define LPM_CLK_MHZ 100
`define LPM_STOP_WAKE_NS 3500
`define LPM_STOP_WAKE_CYC ((`LPM_STOP_WAKE_NS * `LPM_CLK_MHZ) / 1000)
`define LPM_STBY_EXIT_NS 60000
`define LPM_STBY_EXIT_CYC ((`LPM_STBY_EXIT_NS * `LPM_CLK_MHZ) / 1000)
`define LPM_STEP_GAP_NS 5000
`define LPM_STEP_GAP_CYC ((`LPM_STEP_GAP_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_SETTLE_CYC 16

`endif

/* common/lpm_pkg.sv */
// lpm_pkg: mode and state types of the power mode controller
// assumes: compiled before every design file
package lpm_pkg;

  typedef enum logic [2:0] {
    LPM_RUN = 3'h0,
    LPM_SLEEP = 3'h1,
    LPM_LPRUN = 3'h2,
    LPM_LPSLEEP = 3'h3,
    LPM_STOP_RTC = 3'h4,
    LPM_STOP_NORTC = 3'h5,
    LPM_STBY_RTC = 3'h6,
    LPM_STBY_NORTC = 3'h7
  } lpm_mode_t;

  typedef enum logic [4:0] {
    LPM_S_RUN = 5'h01,
    LPM_S_SLEEP = 5'h02,
    LPM_S_STOP = 5'h04,
    LPM_S_STBY = 5'h08,
    LPM_S_WAKE = 5'h10
  } lpm_state_t;

endpackage

/* rtl/lpm_ctrl.sv */
// lpm_ctrl: low-power mode sequencer, clock/regulator gating, wakeup
// assumes: one clock, inputs synchronous, simple strobe register port
`timescale 1ns/10ps
`include "lpm_defs.svh"

module lpm_ctrl #(
  parameter int GPIO_W = 16,
  parameter int WPIN_W = 3,
  parameter int STBY_EXIT = `LPM_STBY_EXIT_CYC
) (
  input wire logic sys_clk, // 100 MHz
  input wire logic rstn, // async, active low
  input wire logic [5:0] addr, // byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, next cycle
  input wire logic periph_irq, // any peripheral irq/event
  input wire logic [GPIO_W-1:0] gpio_evt, // gpio event lines
  input wire logic vdet_evt, // supply voltage detector
  input wire logic cmp1_evt, // comparator 1
  input wire logic cmp2_evt, // comparator 2
  input wire logic vref_on, // internal reference on
  input wire logic rtc_evt, // clock alarm/tamper/stamp/wake
  input wire logic periph_wake, // usb/serial/i2c/timer wake
  input wire logic periph_fast_req, // fast osc request in stop
  input wire logic ext_reset_pin_n, // external reset pin
  input wire logic independent_watchdog_reset, // watchdog reset
  input wire logic [WPIN_W-1:0] wakeup_pin, // wakeup pins
  output lpm_pkg::lpm_mode_t req_mode, // last requested mode
  output logic cpu_clk_en, // cpu clock gate
  output logic periph_clk_en, // core-domain clock gate
  output logic pll_en, // pll enable
  output logic multispeed_osc_en, // multispeed osc
  output logic fast_internal_osc_en, // fast internal osc
  output logic slow_internal_osc_en, // slow internal osc
  output logic slow_crystal_osc_en, // slow crystal osc
  output logic independent_watchdog_run, // independent watchdog runs
  output logic regulator_lp, // regulator low-power
  output logic regulator_off, // regulator off
  output logic core_pwr_en, // core domain powered
  output logic ram_retain, // ram/registers kept
  output logic core_rst_n, // core reset, active low
  output logic [15:0] cpu_freq_khz, // applied cpu clock
  output logic flash_wait_state, // one flash wait state
  output logic wake_pulse, // wakeup to cpu, one cycle
  output logic irq // level interrupt
);
  import lpm_pkg::*;

  localparam int STOP_WAKE_MAX = `LPM_STOP_WAKE_CYC;
  localparam int GAP = `LPM_STEP_GAP_CYC;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_q;
  wire rst_n = rst_q[1];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  function automatic logic [15:0] range_max(input logic [1:0] r);
    case (r)
      2'h1: range_max = `LPM_R1_MAX;
      2'h2: range_max = `LPM_R2_MAX;
      default: range_max = `LPM_R3_MAX;
    endcase
  endfunction

  function automatic logic needs_ws(input logic [1:0] r,
                                    input logic [15:0] f);
    case (r)
      2'h1: needs_ws = f > `LPM_WS_R1;
      2'h2: needs_ws = f > `LPM_WS_R2;
      default: needs_ws = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  lpm_state_t state, next_state;
  lpm_mode_t mode_q;
  logic [1:0] range_q;
  logic lsi_en, lse_en, independent_watchdog_en;
  logic [15:0] freq_q;
  logic [9:0] gap_cnt;
  logic lp_q, from_stby;
  logic [4:0] settle;
  logic [WPIN_W-1:0] wpin_q;
  logic [`LPM_IRQ_W-1:0] irq_stat, irq_en;
  logic ws_q, wake_q;
  logic [12:0] exit_cnt;

  wire s_run = state == LPM_S_RUN;
  wire s_sleep = state == LPM_S_SLEEP;
  wire s_stop = state == LPM_S_STOP;
  wire s_stby = state == LPM_S_STBY;
  wire s_wake = state == LPM_S_WAKE;

  wire sel_ctrl = addr == `LPM_A_CTRL;
  wire sel_freq = addr == `LPM_A_FREQ;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_freq = wr & sel_freq;
  wire wr_irqc = wr & (addr == `LPM_A_IRQC);
  wire wr_irqe = wr & (addr == `LPM_A_IRQE);
  wire lpm_mode_t new_mode = lpm_mode_t'(wdata[`LPM_F_MODE]);

  // with-clock variants have the low mode bit clear
  wire with_rtc = !mode_q[0];
  wire nortc_lp = (s_stop | s_stby | (s_wake & from_stby)) & !with_rtc;

  // ----------------------------------------
  // entry request
  // ----------------------------------------
  wire want_lp = new_mode == LPM_LPRUN || new_mode == LPM_LPSLEEP;
  // low-power regulator cannot carry fast clocks
  wire lp_bad = want_lp & (freq_q > `LPM_LPRUN_MAX);
  wire go = wr_ctrl & wdata[`LPM_F_GO] & s_run;
  wire go_ok = go & !lp_bad;
  wire refuse = go & lp_bad;

  // ----------------------------------------
  // wake sources
  // ----------------------------------------
  wire [WPIN_W-1:0] wpin_rise = wakeup_pin & ~wpin_q;
  wire stop_wake = |gpio_evt | vdet_evt | cmp1_evt
                 | (cmp2_evt & vref_on) | periph_wake
                 | (rtc_evt & with_rtc);
  wire stby_wake = !ext_reset_pin_n | (|wpin_rise)
                 | (with_rtc & (independent_watchdog_reset | rtc_evt));

  // ----------------------------------------
  // frequency step check
  // ----------------------------------------
  wire [15:0] new_freq = wdata[15:0];
  wire [17:0] four_new = {new_freq, 2'h0};
  wire step_ok = ({2'h0, freq_q} < four_new)
               & (gap_cnt == 10'h0)
               & (new_freq != 16'h0)
               & (new_freq <= range_max(range_q))
               & !(lp_q & (new_freq > `LPM_LPRUN_MAX));
  wire freq_take = wr_freq & step_ok;
  wire step_err = wr_freq & !step_ok;

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  wire settled = settle == 5'(`LPM_SETTLE_CYC - 1);

  always_comb begin
    next_state = state;
    case (state)
      LPM_S_RUN: begin
        if (go_ok) begin
          case (new_mode)
            LPM_SLEEP, LPM_LPSLEEP: next_state = LPM_S_SLEEP;
            LPM_STOP_RTC, LPM_STOP_NORTC: next_state = LPM_S_STOP;
            LPM_STBY_RTC, LPM_STBY_NORTC: next_state = LPM_S_STBY;
            default: next_state = LPM_S_RUN;
          endcase
        end
      end
      LPM_S_SLEEP: begin
        if (periph_irq) begin
          next_state = LPM_S_RUN;
        end
      end
      LPM_S_STOP: begin
        if (stop_wake) begin
          next_state = LPM_S_WAKE;
        end
      end
      LPM_S_STBY: begin
        if (stby_wake) begin
          next_state = LPM_S_WAKE;
        end
      end
      LPM_S_WAKE: begin
        if (settled) begin
          next_state = LPM_S_RUN;
        end
      end
      default: next_state = LPM_S_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LPM_S_RUN;
    end else begin
      state <= next_state;
    end
  end

  // osc restart allowance, well inside the wake limits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 5'h0;
    end else if (s_wake) begin
      settle <= settle + 5'h1;
    end else begin
      settle <= 5'h0;
    end
  end

  // lp regulator held from entry until the next accepted go request or the wake from sleep
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_q <= 1'b0;
    end else if (go_ok) begin
      lp_q <= want_lp;
    end else if (s_sleep & periph_irq) begin
      lp_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      from_stby <= 1'b0;
    end else if (s_stby) begin
      from_stby <= 1'b1;
    end else if (s_run) begin
      from_stby <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wpin_q <= '0;
    end else begin
      wpin_q <= wakeup_pin;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= LPM_RUN;
      range_q <= `LPM_RANGE_RST;
      lsi_en <= 1'b1;
      lse_en <= 1'b0;
      independent_watchdog_en <= 1'b0;
    end else if (wr_ctrl & s_run) begin
      mode_q <= new_mode;
      range_q <= wdata[`LPM_F_RANGE];
      lsi_en <= wdata[`LPM_F_LSI];
      lse_en <= wdata[`LPM_F_LSE];
      independent_watchdog_en <= wdata[`LPM_F_INDEPENDENT_WATCHDOG];
    end
  end

  // refused steps leave the clock as it was
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_q <= `LPM_FREQ_RST;
      gap_cnt <= 10'h0;
    end else if (freq_take) begin
      freq_q <= new_freq;
      gap_cnt <= 10'(GAP - 1);
    end else if (gap_cnt != 10'h0) begin
      gap_cnt <= gap_cnt - 10'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ws_q <= 1'b0;
    end else begin
      ws_q <= needs_ws(range_q, freq_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= s_wake & settled;
    end
  end

  // ----------------------------------------
  // interrupts: set wins over clear
  // ----------------------------------------
  wire [`LPM_IRQ_W-1:0] irq_set = {step_err, refuse, wake_q};
  wire [`LPM_IRQ_W-1:0] irq_clr = wr_irqc ? wdata[`LPM_IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_en <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_irqe) begin
        irq_en <= wdata[`LPM_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [31:0] rd_mux =
      sel_ctrl ? {23'h0, independent_watchdog_en, lse_en, lsi_en, range_q, 1'b0, mode_q}
    : sel_freq ? {16'h0, freq_q}
    : addr == `LPM_A_STAT ? {21'h0, regulator_lp, ws_q, lp_q, state, mode_q}
    : addr == `LPM_A_IRQS ? {29'h0, irq_stat}
    : addr == `LPM_A_IRQE ? {29'h0, irq_en}
    : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire awake = s_run | s_sleep;
  assign req_mode = mode_q;
  assign cpu_clk_en = s_run;
  assign periph_clk_en = awake;
  assign pll_en = awake & !lp_q;
  assign multispeed_osc_en = awake | s_wake;
  assign fast_internal_osc_en = (awake & !lp_q)
                              | (s_stop & periph_fast_req);
  assign slow_internal_osc_en = lsi_en & !nortc_lp;
  assign slow_crystal_osc_en = lse_en & !nortc_lp;
  assign independent_watchdog_run = independent_watchdog_en;
  assign regulator_lp = lp_q | s_stop;
  assign regulator_off = s_stby;
  assign core_pwr_en = !s_stby;
  assign ram_retain = !s_stby & !(s_wake & from_stby);
  // standby exit restarts the core as after reset
  assign core_rst_n = rst_n & !s_stby & !(s_wake & from_stby);
  assign cpu_freq_khz = freq_q;
  assign flash_wait_state = ws_q;
  assign wake_pulse = wake_q;
  assign irq = |(irq_stat & irq_en);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_cnt <= 13'h0;
    end else if (s_stby & stby_wake) begin
      exit_cnt <= 13'h1;
    end else if (exit_cnt != 13'h0 && !s_run) begin
      exit_cnt <= exit_cnt + 13'h1;
    end else begin
      exit_cnt <= 13'h0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_sleep_clocks: assert property (
    s_sleep |-> !cpu_clk_en && periph_clk_en)
    else $error("sleep clock gating wrong");
  a_lprun_slow: assert property (
    s_run && lp_q |-> freq_q <= `LPM_LPRUN_MAX && regulator_lp && !pll_en)
    else $error("low-power run above limit");
  a_lpsleep_exit: assert property (
    s_sleep && lp_q && periph_irq |=> s_run && !regulator_lp)
    else $error("low-power sleep exit wrong");
  a_stop_clocks: assert property (
    s_stop |-> !pll_en && !multispeed_osc_en && regulator_lp && !periph_clk_en)
    else $error("stop clocks not off");
  a_stop_fast: assert property (
    s_stop && periph_fast_req |-> fast_internal_osc_en)
    else $error("fast osc request ignored");
  a_stop_wake: assert property (
    s_stop && stop_wake |-> ##[1:STOP_WAKE_MAX] wake_pulse)
    else $error("stop wake too slow");
  a_stop_nortc: assert property (
    s_stop && !with_rtc |-> !slow_internal_osc_en && !slow_crystal_osc_en)
    else $error("slow osc on in stop");
  a_stop_keep: assert property (
    s_stop |-> ram_retain && core_pwr_en)
    else $error("stop lost state");
  a_stby_off: assert property (
    s_stby |-> regulator_off && !core_pwr_en && !core_rst_n)
    else $error("standby still powered");
  a_stby_exit: assert property (
    exit_cnt < 13'(STBY_EXIT))
    else $error("standby exit too slow");
  a_wait_state: assert property (
    range_q == 2'h1 && $stable(range_q) && $stable(freq_q)
      && freq_q > `LPM_WS_R1 |=> flash_wait_state)
    else $error("missing wait state");
  a_step_gap: assert property (
    freq_take |=> !freq_take [*8])
    else $error("step taken too soon");

  c_stop_wake: cover property (s_stop ##1 s_wake [*2] ##[1:40] wake_pulse);
  c_stby_exit: cover property (s_stby ##1 s_wake ##[1:40] s_run);
  c_lpsleep: cover property (s_sleep && lp_q ##1 s_run);
  c_refuse: cover property (refuse);

endmodule

/* test/lpm_wake_model.sv */
// lpm_wake_model: wake sources and peripherals facing the controller
// assumes: bench fires one source at a time; cpu_awake is the cpu clock gate
`timescale 1ns/10ps

module lpm_wake_model (
  input wire logic sys_clk, // system clock
  input wire logic fire, // load a new source
  input wire logic [3:0] src, // source index, 4'hf drops all
  input wire logic cpu_awake, // cpu running again
  output logic periph_irq, // sleep wake
  output logic [15:0] gpio_evt, // event lines
  output logic vdet_evt, // voltage detector
  output logic cmp1_evt, // comparator 1
  output logic cmp2_evt, // comparator 2
  output logic rtc_evt, // alarm, tamper, stamp, wake
  output logic periph_wake, // serial, bus, timer wake
  output logic independent_watchdog_reset, // watchdog reset
  output logic ext_reset_pin_n, // reset pin, active low
  output logic [2:0] wakeup_pin // wakeup pins
);
  logic [9:0] act = 10'h000;

  // ----------------------------------------
  // source held like a pending line
  // ----------------------------------------
  // a source drops once the cpu runs or a new one is fired, so a slow wake still sees it
  always @(posedge sys_clk) begin
    if (fire) begin
      act <= 10'h001 << src;
    end else if (cpu_awake) begin
      act <= 10'h000;
    end
  end

  assign periph_irq = act[0];
  assign gpio_evt = {act[1], 15'h0000};
  assign vdet_evt = act[2];
  assign cmp1_evt = act[3];
  assign cmp2_evt = act[4];
  assign rtc_evt = act[5];
  assign periph_wake = act[6];
  assign independent_watchdog_reset = act[7];
  assign ext_reset_pin_n = ~act[8];
  assign wakeup_pin = {act[9], 2'h0};
endmodule

/* test/tb_top.sv */
// tb_top: register-level tests of the power mode controller
// assumes: lpm_wake_model drives every wake source of the controller
`timescale 1ns/10ps

module tb_top;
  import lpm_pkg::*;
  logic sys_clk, rstn, wr, rd, fire, vref_on, periph_fast_req, seen;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, cfg, v;
  logic [3:0] src;
  logic periph_irq, vdet_evt, cmp1_evt, cmp2_evt, rtc_evt, periph_wake, ext_reset_pin_n, independent_watchdog_reset;
  logic [15:0] gpio_evt, cpu_freq_khz;
  logic [2:0] wakeup_pin;
  lpm_mode_t req_mode;
  logic cpu_clk_en, periph_clk_en, pll_en, multispeed_osc_en, fast_internal_osc_en, slow_internal_osc_en;
  logic slow_crystal_osc_en, independent_watchdog_run, regulator_lp, regulator_off, core_pwr_en, ram_retain, core_rst_n;
  logic flash_wait_state, wake_pulse, irq;
  int miscompares, comparisons;

  lpm_ctrl dut (.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .periph_irq, .gpio_evt, .vdet_evt,
    .cmp1_evt, .cmp2_evt, .vref_on, .rtc_evt, .periph_wake, .periph_fast_req, .ext_reset_pin_n, .independent_watchdog_reset,
    .wakeup_pin, .req_mode, .cpu_clk_en, .periph_clk_en, .pll_en, .multispeed_osc_en, .fast_internal_osc_en,
    .slow_internal_osc_en, .slow_crystal_osc_en, .independent_watchdog_run, .regulator_lp, .regulator_off, .core_pwr_en,
    .ram_retain, .core_rst_n, .cpu_freq_khz, .flash_wait_state, .wake_pulse, .irq);

  lpm_wake_model wake_src (.sys_clk, .fire, .src, .cpu_awake(cpu_clk_en), .periph_irq, .gpio_evt,
    .vdet_evt, .cmp1_evt, .cmp2_evt, .rtc_evt, .periph_wake, .independent_watchdog_reset, .ext_reset_pin_n, .wakeup_pin);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // checks and verdict
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (!(got === exp)) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // register port and wake helpers
  // ----------------------------------------
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd32(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic enter(input logic [2:0] m);
    wr32(6'h00, cfg | 32'h8 | {29'h0, m});
  endtask

  task automatic poke(input logic [3:0] s);
    @(posedge sys_clk);
    fire <= 1'b1;
    src <= s;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask

  task automatic wait_pulse(input int lim);
    seen = 1'b0;
    for (int n = 0; n < lim && seen !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1 seen = wake_pulse;
    end
  endtask

  // an ignored source is followed by a sure one so the run can go on
  task automatic wake_try(input logic [2:0] m, input logic [3:0] s, input int lim, input logic exp);
    enter(m);
    poke(s);
    wait_pulse(lim);
    chk1("wake_pulse", exp, seen);
    if (seen !== 1'b1) begin
      poke(m[1] ? 4'h9 : 4'h1);
      wait_pulse(6000);
    end
  endtask

  // steps need a gap of 500 cycles after the last accepted one
  task automatic set_freq(input logic [15:0] f, input logic ok, input logic gap);
    logic [15:0] old;
    if (gap) begin
      repeat (510) @(posedge sys_clk);
    end
    old = cpu_freq_khz;
    wr32(6'h04, {16'h0, f});
    repeat (2) @(posedge sys_clk);
    #1 chk("cpu_freq_khz", {16'h0, ok ? f : old}, {16'h0, cpu_freq_khz});
    rd32(6'h0c, v);
    chk1("step_error", !ok, v[2]);
    wr32(6'h10, 32'h4);
  endtask

  // ----------------------------------------
  // watchdog: whole run needs about 32000 cycles
  // ----------------------------------------
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    {wr, rd, fire, periph_fast_req} = 4'h0;
    addr = 6'h00;
    wdata = 32'h0;
    src = 4'h0;
    vref_on = 1'b1;
    cfg = 32'h1e0;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("cpu_freq_khz", 32'h831, {16'h0, cpu_freq_khz});
    chk1("flash_wait_state", 1'b0, flash_wait_state);
    rd32(6'h08, v);
    chk("status", 32'h8, v);
    rd32(6'h3c, v);
    chk("unmapped", 32'h0, v);
    enter(LPM_SLEEP);
    chk("req_mode", 32'h1, {29'h0, req_mode});
    chk1("cpu_clk_en", 1'b0, cpu_clk_en);
    chk("periph_pll_msi", 32'h7, {29'h0, periph_clk_en, pll_en, multispeed_osc_en});
    poke(4'h0);
    repeat (3) @(posedge sys_clk);
    #1 chk1("cpu_clk_en", 1'b1, cpu_clk_en);
    wr32(6'h14, 32'h1);
    enter(LPM_LPRUN);
    rd32(6'h0c, v);
    chk1("refused", 1'b1, v[1]);
    chk1("irq", 1'b0, irq);
    chk1("regulator_lp", 1'b0, regulator_lp);
    wr32(6'h14, 32'h7);
    chk1("irq", 1'b1, irq);
    wr32(6'h10, 32'h7);
    chk1("irq", 1'b0, irq);
    set_freq(16'd600, 1'b1, 1'b1);
    set_freq(16'd160, 1'b1, 1'b1);
    set_freq(16'd131, 1'b1, 1'b1);
    enter(LPM_LPRUN);
    chk("lp_msi_cpu", 32'h7, {29'h0, regulator_lp, multispeed_osc_en, cpu_clk_en});
    set_freq(16'd132, 1'b0, 1'b1);
    enter(LPM_LPSLEEP);
    chk("cpu_lp", 32'h1, {30'h0, cpu_clk_en, regulator_lp});
    poke(4'h0);
    repeat (3) @(posedge sys_clk);
    #1 chk("cpu_lp", 32'h2, {30'h0, cpu_clk_en, regulator_lp});
    set_freq(16'd500, 1'b1, 1'b1);
    set_freq(16'd1900, 1'b1, 1'b1);
    set_freq(16'd7000, 1'b1, 1'b1);
    chk1("flash_wait_state", 1'b0, flash_wait_state);
    set_freq(16'd9000, 1'b1, 1'b1);
    chk1("flash_wait_state", 1'b1, flash_wait_state);
    set_freq(16'd10000, 1'b0, 1'b0);
    set_freq(16'd17000, 1'b0, 1'b1);
    cfg = 32'h1d0;
    wr32(6'h00, cfg);
    repeat (2) @(posedge sys_clk);
    #1 chk1("flash_wait_state", 1'b0, flash_wait_state);
    set_freq(16'd20000, 1'b1, 1'b1);
    chk1("flash_wait_state", 1'b1, flash_wait_state);
    set_freq(16'd32001, 1'b0, 1'b1);
    set_freq(16'd4000, 1'b0, 1'b1);
    enter(LPM_STOP_RTC);
    chk("clocks_off", 32'h0, {27'h0, cpu_clk_en, periph_clk_en, pll_en, multispeed_osc_en,
      fast_internal_osc_en});
    chk("lp_lse_wdg_ram", 32'hf, {28'h0, regulator_lp, slow_crystal_osc_en, independent_watchdog_run, ram_retain});
    @(posedge sys_clk);
    periph_fast_req <= 1'b1;
    @(posedge sys_clk);
    #1 chk1("fast_internal_osc_en", 1'b1, fast_internal_osc_en);
    @(posedge sys_clk);
    periph_fast_req <= 1'b0;
    wake_try(LPM_STOP_RTC, 4'h1, 350, 1'b1);
    // wake status bit lands one edge after the pulse
    @(posedge sys_clk);
    #1 chk1("irq", 1'b1, irq);
    wr32(6'h10, 32'h1);
    rd32(6'h04, v);
    chk("freq_kept", 32'd20000, v);
    for (int s = 2; s <= 6; s++) begin
      wake_try(LPM_STOP_RTC, s[3:0], 350, 1'b1);
    end
    @(posedge sys_clk);
    vref_on <= 1'b0;
    wake_try(LPM_STOP_RTC, 4'h4, 350, 1'b0);
    @(posedge sys_clk);
    vref_on <= 1'b1;
    enter(LPM_STOP_NORTC);
    chk("slow_oscs", 32'h0, {30'h0, slow_internal_osc_en, slow_crystal_osc_en});
    wake_try(LPM_STOP_NORTC, 4'h5, 400, 1'b0);
    wake_try(LPM_STOP_NORTC, 4'h3, 350, 1'b1);
    enter(LPM_STBY_RTC);
    chk("core_off", 32'h8, {28'h0, regulator_off, core_pwr_en, ram_retain, core_rst_n});
    chk("lse_wdg", 32'h3, {30'h0, slow_crystal_osc_en, independent_watchdog_run});
    for (int s = 5; s <= 9; s++) begin
      wake_try(LPM_STBY_RTC, s[3:0], 6000, s != 6);
    end
    for (int s = 5; s <= 9; s++) begin
      wake_try(LPM_STBY_NORTC, s[3:0], 6000, s >= 8);
    end
    report_and_stop();
  end
endmodule
